// File: hdl/sct_seconds_timer.v
/*
  Seconds timer: a 32-bit count fed by a 16-bit prescaler of the slow clock,
  an alarm compare, tick and alarm flags, one level interrupt and a Wishbone slave.
  Register map, byte addresses:
    0x0 timer mode: prescale divisor, alarm and tick enables, restart command
    0x4 alarm compare value
    0x8 current count, read only
    0xc event status: alarm flag in bit 0, tick flag in bit 1, cleared by a read
  Restarts and flag clears wait for a slow tick, then cross two slow-tick
  stages, so they land two to three slow periods after the bus access.
  The interrupt follows the flags a cycle later and stays up until the
  delayed clear lands.
  Assumes a classic Wishbone master holding each request until ack; every
  access is answered one cycle after it is taken.
  The slow clock is an enable pulse derived from the master clock, so all
  state lives in one clock domain.
*/
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ns
`include "sct_consts.vh"
module sct_seconds_timer #(
  parameter [31:0] SLOW_DIV = `SCT_SLOW_DIV
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         irq
);

  // Reset image of the mode word and the prescaler load that gives its first period
  localparam [31:0] MODE_RESET  = `SCT_MODE_RESET;
  localparam [15:0] PRESC_RESET = MODE_RESET[`SCT_PRESC_MSB:`SCT_PRESC_LSB];
  localparam [15:0] PRESC_START = PRESC_RESET - 16'h0001;

  // Software-visible state
  reg  [15:0] prescale_divisor;
  reg         alarm_irq_enable;
  reg         tick_irq_enable;
  reg  [31:0] alarm_compare_value;
  reg  [31:0] current_count;
  reg         alarm_hit_flag;
  reg         tick_flag;

  // Prescaler state
  reg  [15:0] presc_left;

  // Requests waiting for the next slow tick, then two slow-tick stages
  reg         restart_pend;
  reg         restart_stage1;
  reg         restart_stage2;
  reg  [1:0]  clear_pend;
  reg  [1:0]  clear_stage1;
  reg  [1:0]  clear_stage2;

  wire        slow_en;
  wire        bus_req;
  wire        bus_wr;
  wire        bus_rd;
  wire        presc_wrap;
  wire [15:0] presc_reload;
  wire [31:0] next_count;
  wire        count_step;
  wire        alarm_match;
  wire [1:0]  clear_now;
  wire        restart_write;
  wire        status_read;
  wire        status_write;
  wire [1:0]  clear_ask;
  wire [1:0]  irq_source;
  reg  [31:0] mode_word;
  reg  [31:0] status_word;
  reg  [31:0] next_rdata;
  reg         next_alarm_flag;
  reg         next_tick_flag;

  sct_slow_tick #(
    .DIV (SLOW_DIV)
  ) u_slow_tick (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (slow_en)
  );

  // One access per request: acted on in the cycle ack is raised
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i;
  assign bus_rd  = bus_req & ~wb_we_i;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Mode and alarm registers, byte lanes honoured
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prescale_divisor    <= PRESC_RESET;
      alarm_irq_enable    <= 1'b0;
      tick_irq_enable     <= 1'b0;
      alarm_compare_value <= `SCT_ALARM_RESET;
    end else if (bus_wr) begin
      if (wb_adr_i == `SCT_ADDR_MODE) begin
        if (wb_sel_i[0]) begin
          prescale_divisor[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          prescale_divisor[15:8] <= wb_dat_i[15:8];
        end
        if (wb_sel_i[2]) begin
          alarm_irq_enable <= wb_dat_i[`SCT_BIT_ALARM_IEN];
          tick_irq_enable  <= wb_dat_i[`SCT_BIT_TICK_IEN];
        end
      end
      if (wb_adr_i == `SCT_ADDR_ALARM) begin
        if (wb_sel_i[0]) begin
          alarm_compare_value[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          alarm_compare_value[15:8] <= wb_dat_i[15:8];
        end
        if (wb_sel_i[2]) begin
          alarm_compare_value[23:16] <= wb_dat_i[23:16];
        end
        if (wb_sel_i[3]) begin
          alarm_compare_value[31:24] <= wb_dat_i[31:24];
        end
      end
    end
  end

  // Requests wait in a pending bit for the next slow tick, then cross two slow-tick stages.
  // Stage two holds between ticks and acts only at a tick, so it is applied exactly once.
  // A request arriving while another still waits in the pending bit merges with it; one already in a stage is applied on its own.
  assign restart_write = bus_wr & (wb_adr_i == `SCT_ADDR_MODE) & wb_sel_i[2] & wb_dat_i[`SCT_BIT_RESTART];
  assign status_read   = bus_rd & (wb_adr_i == `SCT_ADDR_STATUS);
  assign status_write  = bus_wr & (wb_adr_i == `SCT_ADDR_STATUS) & wb_sel_i[0];
  assign clear_ask     = status_read ? 2'h3 : (status_write ? wb_dat_i[1:0] : 2'h0);

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      restart_pend   <= 1'b0;
      restart_stage1 <= 1'b0;
      restart_stage2 <= 1'b0;
    end else if (slow_en) begin
      restart_pend   <= 1'b0;
      restart_stage1 <= restart_pend | restart_write;
      restart_stage2 <= restart_stage1;
    end else begin
      restart_pend   <= restart_pend | restart_write;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clear_pend   <= 2'h0;
      clear_stage1 <= 2'h0;
      clear_stage2 <= 2'h0;
    end else if (slow_en) begin
      clear_pend   <= 2'h0;
      clear_stage1 <= clear_pend | clear_ask;
      clear_stage2 <= clear_stage1;
    end else begin
      clear_pend   <= clear_pend | clear_ask;
    end
  end

  // Prescaler: counts down; zero divisor reloads 16'hffff, a 65536 period
  assign presc_reload = prescale_divisor - 16'h0001;
  assign presc_wrap   = (presc_left == 16'h0000);
  assign count_step   = slow_en & presc_wrap & ~restart_stage2;
  assign next_count   = current_count + 32'h00000001;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      presc_left    <= PRESC_START;
      current_count <= `SCT_VALUE_RESET;
    end else if (slow_en) begin
      if (restart_stage2) begin
        presc_left    <= presc_reload;
        current_count <= `SCT_VALUE_RESET;
      end else if (presc_wrap) begin
        presc_left    <= presc_reload;
        current_count <= next_count;
      end else begin
        presc_left <= presc_left - 16'h0001;
      end
    end
  end

  // Flags: set wins over a clear landing in the same slow tick
  assign alarm_match = slow_en & (current_count == alarm_compare_value);
  assign clear_now   = slow_en ? clear_stage2 : 2'h0;

  // The alarm flag sets again at every slow tick while the count still
  // equals the compare value, so a clear during that time does not stick.
  always @* begin
    next_alarm_flag = alarm_hit_flag;
    if (clear_now[`SCT_BIT_ALARM_FLAG]) begin
      next_alarm_flag = 1'b0;
    end
    if (alarm_match) begin
      next_alarm_flag = 1'b1;
    end
  end

  // A flag set between a status read and its delayed clear is lost; short divisors make that likely
  always @* begin
    next_tick_flag = tick_flag;
    if (clear_now[`SCT_BIT_TICK_FLAG]) begin
      next_tick_flag = 1'b0;
    end
    if (count_step) begin
      next_tick_flag = 1'b1;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alarm_hit_flag <= 1'b0;
    end else begin
      alarm_hit_flag <= next_alarm_flag;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_flag <= 1'b0;
    end else begin
      tick_flag <= next_tick_flag;
    end
  end

  // Interrupt sources, one per status bit, each gated by its enable
  assign irq_source[`SCT_BIT_ALARM_FLAG] = alarm_hit_flag & alarm_irq_enable;
  assign irq_source[`SCT_BIT_TICK_FLAG]  = tick_flag & tick_irq_enable;

  // Registered, so irq trails the flags by a cycle and stays up until the clear lands
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |irq_source;
    end
  end

  // Read data; restart is a command and reads as zero, unmapped addresses read zero
  always @* begin
    mode_word                                = 32'h00000000;
    mode_word[`SCT_PRESC_MSB:`SCT_PRESC_LSB] = prescale_divisor;
    mode_word[`SCT_BIT_ALARM_IEN]            = alarm_irq_enable;
    mode_word[`SCT_BIT_TICK_IEN]             = tick_irq_enable;
  end

  always @* begin
    status_word                      = 32'h00000000;
    status_word[`SCT_BIT_ALARM_FLAG] = alarm_hit_flag;
    status_word[`SCT_BIT_TICK_FLAG]  = tick_flag;
  end

  always @* begin
    next_rdata = 32'h00000000;
    case (wb_adr_i)
      `SCT_ADDR_MODE: begin
        next_rdata = mode_word;
      end
      `SCT_ADDR_ALARM: begin
        next_rdata = alarm_compare_value;
      end
      `SCT_ADDR_VALUE: begin
        next_rdata = current_count;
      end
      `SCT_ADDR_STATUS: begin
        next_rdata = status_word;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_rd) begin
      wb_dat_o <= next_rdata;
    end
  end

endmodule // sct_seconds_timer

// File: hdl/sct_consts.vh
/*
  Constants for the seconds timer: register offsets, field positions,
  reset values and the default slow-tick divider count.
  Assumes a 32-bit classic Wishbone slave decoding byte addresses.
*/
`ifndef SCT_CONSTS_VH
`define SCT_CONSTS_VH

`define SCT_ADDR_MODE       4'h0
`define SCT_ADDR_ALARM      4'h4
`define SCT_ADDR_VALUE      4'h8
`define SCT_ADDR_STATUS     4'hc

`define SCT_MODE_RESET      32'h00008000
`define SCT_ALARM_RESET     32'hffffffff
`define SCT_VALUE_RESET     32'h00000000
`define SCT_STATUS_RESET    32'h00000000

`define SCT_PRESC_LSB       0
`define SCT_PRESC_MSB       15
`define SCT_BIT_ALARM_IEN   16
`define SCT_BIT_TICK_IEN    17
`define SCT_BIT_RESTART     18

`define SCT_BIT_ALARM_FLAG  0
`define SCT_BIT_TICK_FLAG   1

// Master clock 250 MHz, slow clock about 32.768 kHz
`define SCT_CLOCK_HZ        250000000
`define SCT_SLOW_HZ         32768
`define SCT_SLOW_DIV        (`SCT_CLOCK_HZ / `SCT_SLOW_HZ)

`endif

// File: hdl/sct_slow_tick.v
/*
  Slow-clock enable generator: a one-cycle pulse every DIV master cycles.
  Assumes DIV is at least 1; DIV of 1 gives a pulse every cycle.
*/
`timescale 1ns/1ns
module sct_slow_tick #(
  parameter [31:0] DIV = 32'd7629
) (
  input  wire        clock,
  input  wire        reset_n,
  output reg         tick
);

  reg  [31:0] count;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= 32'h00000000;
      tick  <= 1'b0;
    end else if (count >= DIV - 32'd1) begin
      count <= 32'h00000000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'd1;
      tick  <= 1'b0;
    end
  end

endmodule // sct_slow_tick

// File: test/sct_seconds_timer_properties.sv
/* Port checker for the seconds timer: bus answer, read-back, mask.
   Assumes alarm writes use all four byte lanes. */
`timescale 1ns/1ns
module sct_seconds_timer_properties (
  input wire        clock,
  input wire        reset_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [3:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        irq
);
  reg  [31:0] alarm_copy;
  wire        req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        rd  = wb_ack_o && !wb_we_i;
  wire        wr0 = wb_ack_o && wb_we_i && wb_adr_i == 4'h0;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) alarm_copy <= 32'hffffffff;
    else if (wb_ack_o && wb_we_i && wb_adr_i == 4'h4) alarm_copy <= wb_dat_i;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_ACK_NEXT: assert property (req |=> wb_ack_o) else $error("no ack");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  AST_QUIET: assert property ($rose(reset_n) |-> !wb_ack_o && !irq) else $error("busy at reset");
  AST_HOLE: assert property (rd && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0) else $error("hole");
  AST_MODE_RB: assert property (rd && wb_adr_i == 4'h0 |-> wb_dat_o[31:18] == 14'h0) else $error("mode");
  AST_STAT_RB: assert property (rd && wb_adr_i == 4'hc |-> wb_dat_o[31:2] == 30'h0) else $error("stat");
  AST_ALARM_RB: assert property (rd && wb_adr_i == 4'h4 |-> wb_dat_o == alarm_copy) else $error("alarm");
  // Clear waits two slow ticks, so irq cannot drop right after the read
  AST_STAT_IRQ: assert property (rd && wb_adr_i == 4'hc && irq |=> irq [*2]) else $error("early");
  AST_MASK_OFF: assert property (wr0 && wb_sel_i[2] && wb_dat_i[17:16] == 2'h0 |=> !irq [*2])
    else $error("mask");
  cover property (rd && wb_adr_i == 4'hc && irq);
  cover property (wr0 && wb_dat_i[18]);
  cover property ($rose(irq));
endmodule // sct_seconds_timer_properties
bind sct_seconds_timer sct_seconds_timer_properties chk_u (.clock(clock), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));

// File: test/sct_seconds_timer_tb.sv
/* Bench for the seconds timer: map, count, restart, irqs.
   Assumes SLOW_DIV 4; a zero divisor is only seen not to count. */
`timescale 1ns/1ns
module sct_seconds_timer_tb;
  reg         clock, reset_n, wb_cyc_i, wb_stb_i, wb_we_i;
  reg  [3:0]  wb_adr_i, wb_sel_i;
  reg  [31:0] wb_dat_i, q, v;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, irq;
  integer     mismatches = 0, num_checks = 0, cyc = 0;
  sct_seconds_timer #(.SLOW_DIV(32'd4)) dut_u (.clock(clock), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));
  task end_sim;
    begin
      if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("BAD %0t %h %h", $time, g, e);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d, output [31:0] r);
    integer n;
    begin
      n = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      @(posedge clock);
      while (wb_ack_o !== 1'b1 && n < 50) begin
        @(posedge clock);
        n = n + 1;
      end
      if (n >= 50) chk(wb_ack_o, 1);
      r = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clock);
    end
  endtask
  task wirq;
    integer n;
    begin
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
        @(posedge clock);
        n = n + 1;
      end
      chk(irq, 1);
    end
  endtask
  // Count read as software should: repeat until two reads in a row agree
  task rdval(output [31:0] r);
    reg [31:0] p;
    integer    k;
    begin
      k = 0;
      bus(0, 4'h8, 0, p);
      bus(0, 4'h8, 0, r);
      while (r !== p && k < 8) begin
        p = r;
        bus(0, 4'h8, 0, r);
        k = k + 1;
      end
      if (r !== p) chk(r, p);
    end
  endtask
  task t_map;
    begin
      bus(0, 4'h0, 0, q); chk(q, 32'h8000);
      bus(0, 4'h4, 0, q); chk(q, 32'hffffffff);
      bus(1, 4'h8, 32'h5, q); bus(0, 4'h8, 0, q); chk(q, 0);
      bus(0, 4'hc, 0, q); chk(q, 0);
      bus(0, 4'h2, 0, q); chk(q, 0);
      bus(1, 4'h4, 32'h12345678, q); bus(0, 4'h4, 0, q); chk(q, 32'h12345678);
    end
  endtask
  task t_count;
    begin
      // New divisor waits for the next wrap or a restart, the old long period still runs
      bus(1, 4'h0, 32'h3, q); repeat (100) @(posedge clock);
      bus(0, 4'h8, 0, q); chk(q, 0);
      bus(1, 4'h0, 32'h40003, q); repeat (40) @(posedge clock);
      // Reads are taken 120 cycles apart, ten whole count periods of 3 x 4 cycles
      bus(0, 4'h8, 0, v); repeat (117) @(posedge clock);
      bus(0, 4'h8, 0, q); chk(q - v, 10);
      bus(0, 4'h0, 0, q); chk(q, 3);
    end
  endtask
  task t_restart;
    begin
      bus(1, 4'h0, 32'h40003, q); bus(0, 4'h8, 0, q); chk(q == 0, 0);
      repeat (20) @(posedge clock);
      rdval(q); chk(q < 3, 1);
    end
  endtask
  task t_alarm;
    begin
      bus(1, 4'h4, 32'h5, q); bus(1, 4'h0, 32'h10003, q);
      wirq;
      bus(0, 4'hc, 0, q); chk(q[0], 1);
      chk(irq, 1);
      repeat (60) @(posedge clock);
      bus(0, 4'hc, 0, q); chk(q[1], 1);
      repeat (60) @(posedge clock);
      chk(irq, 0);
    end
  endtask
  task t_tick;
    begin
      bus(1, 4'h0, 32'h20003, q);
      wirq;
      bus(1, 4'h0, 32'h3, q); @(posedge clock);
      chk(irq, 0);
      // Zero divisor means a 65536-tick period, so the restarted count stays at zero
      bus(1, 4'h0, 32'h40000, q);
      repeat (100) @(posedge clock);
      rdval(q);
      chk(q, 0);
    end
  endtask
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end
  initial begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
    repeat (20) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    t_map;
    t_count;
    t_restart;
    t_alarm;
    t_tick;
    end_sim;
  end
endmodule // sct_seconds_timer_tb
